// >>> verilog/audio_port_defs.svh
`ifndef AUDIO_PORT_DEFS_SVH
`define AUDIO_PORT_DEFS_SVH

// ****************************************************************
// Register byte offsets (low 12 address bits)
// ****************************************************************
`define OFS_CLK_CTRL    12'h000
`define OFS_CODEC_CFG   12'h004
`define OFS_AUX_CFG     12'h008
`define OFS_STATUS      12'h00c

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CK_SRC_LSB      0
`define CK_FORCE_BIT    2
`define CK_REF_BIT      3
`define CK_CTRL_RST     4'h2
`define SRC_MAN_PLL     2'h1
`define PC_ROLE_BIT     0
`define PC_FMT_LSB      1
`define PC_SPD_LSB      3
`define PC_DIV_LSB      5
`define PC_AUXSRC_BIT   8
`define PC_CFG_RST      9'h020
`define ST_ON_PLL       0
`define ST_LOCK         1
`define ST_PEND         2

// ****************************************************************
// Frame and slot counts, in bit clock periods
// ****************************************************************
`define OFF_NORM_LAST   5'h1f
`define OFF_OLM_LAST    5'h13
`define WLEN_NORM       5'h18
`define WLEN_OLM        5'h14
`define DLY_I2S         5'h01
`define DLY_RJ          5'h08
`define FRAME_NORM_LAST 7'h3f
`define FRAME_OLM_LAST  7'h7f
`define HALF_NORM       7'h20
`define HALF_OLM        7'h40
`define SLOT_IDLE       3'h6
`define EXT_BIT_LAST    6'h17

`endif

// >>> verilog/audio_port_pkg.sv
package audio_port_pkg;

  // Serial data formats
  typedef enum logic [1:0] {
    FMT_LJ  = 2'b00,
    FMT_I2S = 2'b01,
    FMT_RJ  = 2'b10,
    FMT_OLM = 2'b11
  } fmt_e;

  // Speed modes; code 11 acts as single speed
  typedef enum logic [1:0] {
    SPD_SINGLE = 2'b00,
    SPD_DOUBLE = 2'b01,
    SPD_QUAD   = 2'b10,
    SPD_RSVD   = 2'b11
  } speed_e;

  // Master clock multiplexer states
  typedef enum logic [1:0] {
    MUX_EXT    = 2'b00,
    MUX_PLL    = 2'b01,
    MUX_TO_EXT = 2'b10,
    MUX_TO_PLL = 2'b11
  } mux_e;

endpackage

// >>> verilog/audio_port_clocking.sv
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "audio_port_defs.svh"

// ****************************************************************
// One serial port: clock generation or sampling, transmit, receive
// ****************************************************************
module serial_port (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // Configuration
  input  wire logic                   mclk_rise,
  input  wire logic                   master,
  input  wire audio_port_pkg::fmt_e   fmt,
  input  wire audio_port_pkg::speed_e spd,
  input  wire logic [2:0]             bclk_half,
  input  wire logic [143:0]           tx_words,
  // Pins
  input  wire logic                   bclk_in,
  output logic                        bclk_out,
  output logic                        bclk_oe,
  input  wire logic                   fclk_in,
  output logic                        fclk_out,
  output logic                        fclk_oe,
  input  wire logic [3:0]             din,
  output logic                        dout,
  // Received words and timing strobes
  output logic [95:0]                 rx_data,
  output logic [2:0]                  rx_slot,
  output logic                        rx_valid,
  output logic                        bit_rise,
  output logic                        frame_edge,
  output logic                        frame_lvl
);
  import audio_port_pkg::*;

  typedef struct packed {
    logic [5:0]   s1;
    logic [5:0]   s2;
    logic [5:0]   s3;
    logic [5:0]   flt;
    logic         bq;
    logic         fq;
    logic [2:0]   divc;
    logic [6:0]   fbit;
    logic         pb;
    logic         pf;
    logic [4:0]   off;
    logic [2:0]   slot;
    logic [143:0] words;
    logic         dout;
    logic [95:0]  sh;
    logic [95:0]  rxd;
    logic [2:0]   rxs;
    logic         rxv;
  } port_s;

  port_s s_r;
  port_s s_nxt;

  // Bit position inside the sample word: {valid, index from MSB}
  function automatic logic [5:0] bit_pos(input logic [4:0] off, input logic [2:0] slot,
                                         input logic [4:0] dly, input logic [4:0] wlen);
    logic [4:0] k;
    k = off - dly;
    bit_pos = {(off >= dly) && (k < wlen) && (slot < `SLOT_IDLE), k};
  endfunction

  // Next state of the whole port
  always_comb
  begin
    logic       single_line_mode;
    logic       i2s;
    logic [4:0] dly;
    logic [4:0] wlen;
    logic [6:0] flast;
    logic [6:0] half;
    logic       b;
    logic       f;
    logic       brise;
    logic       bfall;
    logic       fedge;
    logic       start;
    logic [5:0] tpos;
    logic [5:0] rpos;
    logic [7:0] widx;
    logic [23:0] word;
    s_nxt = s_r;
    single_line_mode   = (fmt == FMT_OLM) && (spd != SPD_QUAD);
    i2s   = (fmt == FMT_I2S);
    dly   = i2s ? `DLY_I2S : ((fmt == FMT_RJ) ? `DLY_RJ : 5'h00);
    wlen  = single_line_mode ? `WLEN_OLM : `WLEN_NORM;
    flast = single_line_mode ? `FRAME_OLM_LAST : `FRAME_NORM_LAST;
    half  = single_line_mode ? `HALF_OLM : `HALF_NORM;
    // Three-stage pin synchroniser, level taken when stages two and three agree
    s_nxt.s1 = {din, fclk_in, bclk_in};
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < 6; i++)
    begin
      if (s_r.s2[i] == s_r.s3[i])
        s_nxt.flt[i] = s_r.s3[i];
    end
    // Master role: bit and frame clocks divided from the master clock
    if (!master)
    begin
      s_nxt.bq   = 1'b0;
      s_nxt.fq   = 1'b0;
      s_nxt.divc = 3'h0;
      s_nxt.fbit = flast;
    end
    else if (mclk_rise)
    begin
      if (s_r.divc == bclk_half)
      begin
        s_nxt.divc = 3'h0;
        s_nxt.bq   = ~s_r.bq;
        if (s_r.bq)
        begin
          s_nxt.fbit = (s_r.fbit >= flast) ? 7'h00 : s_r.fbit + 7'h01;
          s_nxt.fq   = (s_nxt.fbit < half) ^ i2s;
        end
      end
      else
        s_nxt.divc = s_r.divc + 3'h1;
    end
    // Effective clock levels and their edges
    b     = master ? s_r.bq : s_r.flt[0];
    f     = master ? s_r.fq : s_r.flt[1];
    brise = b & ~s_r.pb;
    bfall = ~b & s_r.pb;
    fedge = f ^ s_r.pf;
    s_nxt.pb = b;
    s_nxt.pf = f;
    // Frame clock edge restarts the slot; left start latches new words
    start = f ^ i2s;
    if (fedge && (!single_line_mode || f))
    begin
      s_nxt.off  = 5'h00;
      s_nxt.slot = (single_line_mode || start) ? 3'h0 : 3'h1;
      if (single_line_mode || start)
        s_nxt.words = tx_words;
    end
    else if (bfall)
    begin
      if (single_line_mode && (s_r.off == `OFF_OLM_LAST))
      begin
        s_nxt.off  = 5'h00;
        s_nxt.slot = (s_r.slot < `SLOT_IDLE) ? s_r.slot + 3'h1 : `SLOT_IDLE;
      end
      else if (s_r.off != `OFF_NORM_LAST)
        s_nxt.off = s_r.off + 5'h01;
    end
    // Transmit MSB first on the falling bit clock edge
    tpos = bit_pos(s_nxt.off, s_nxt.slot, dly, wlen);
    widx = tpos[5] ? ({5'h00, s_nxt.slot} * 8'h18) : 8'h00;
    word = s_nxt.words[widx +: 24];
    if (fedge || bfall)
      s_nxt.dout = tpos[5] & word[5'h17 - tpos[4:0]];
    // Receive on the rising bit clock edge, MSB aligned
    rpos      = bit_pos(s_r.off, s_r.slot, dly, wlen);
    s_nxt.rxv = 1'b0;
    if (brise && rpos[5])
    begin
      for (int l = 0; l < 4; l++)
      begin
        s_nxt.sh[l*24 +: 24] = {s_r.sh[l*24 +: 23], s_r.flt[2+l]};
        if (rpos[4:0] == wlen - 5'h01)
          s_nxt.rxd[l*24 +: 24] = single_line_mode ? {s_r.sh[l*24 +: 19], s_r.flt[2+l], 4'h0}
                                      : {s_r.sh[l*24 +: 23], s_r.flt[2+l]};
      end
      if (rpos[4:0] == wlen - 5'h01)
      begin
        s_nxt.rxv = 1'b1;
        s_nxt.rxs = s_r.slot;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // Pin and strobe outputs
  assign bclk_out   = s_r.bq & master; // Low at once when the role drops
  assign bclk_oe    = master;
  assign fclk_out   = s_r.fq & master;
  assign fclk_oe    = master;
  assign dout       = s_r.dout;
  assign rx_data    = s_r.rxd;
  assign rx_slot    = s_r.rxs;
  assign rx_valid   = s_r.rxv;
  assign bit_rise   = (master ? s_r.bq : s_r.flt[0]) & ~s_r.pb;
  assign frame_lvl  = master ? s_r.fq : s_r.flt[1];
  assign frame_edge = frame_lvl ^ s_r.pf;

endmodule // serial_port

// ****************************************************************
// Top: register slave, master clock selection, two serial ports
// ****************************************************************
module audio_port_clocking (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Master clock sources
  input  wire logic        ext_master_clk_in,
  input  wire logic        pll_clk_in,
  input  wire logic        pll_lock_in,
  output logic             mclk_out,
  output logic             pll_frame_ref_sel,
  output logic             force_lock_bit,
  // Codec port pins
  input  wire logic        codec_port_bit_clk_in,
  output logic             codec_port_bit_clk_out,
  output logic             codec_port_bit_clk_oe,
  input  wire logic        codec_port_frame_clk_in,
  output logic             codec_port_frame_clk_out,
  output logic             codec_port_frame_clk_oe,
  input  wire logic        codec_data_in_1,
  input  wire logic        codec_data_in_2,
  input  wire logic        codec_data_in_3,
  input  wire logic        codec_data_in_4,
  output logic             codec_data_out,
  input  wire logic        ext_conv_in_1,
  input  wire logic        ext_conv_in_2,
  // Aux port pins
  input  wire logic        aux_port_bit_clk_in,
  output logic             aux_port_bit_clk_out,
  output logic             aux_port_bit_clk_oe,
  input  wire logic        aux_port_frame_clk_in,
  output logic             aux_port_frame_clk_out,
  output logic             aux_port_frame_clk_oe,
  output logic             aux_data_out,
  // Sample sources
  input  wire logic [23:0] adc1_sample,
  input  wire logic [23:0] adc2_sample,
  input  wire logic [23:0] spdif_left,
  input  wire logic [23:0] spdif_right,
  // Received DAC samples
  output logic [23:0]      dac_data_1,
  output logic [23:0]      dac_data_2,
  output logic [23:0]      dac_data_3,
  output logic [23:0]      dac_data_4,
  output logic [2:0]       dac_slot,
  output logic             dac_valid
);
  import audio_port_pkg::*;

  typedef struct packed {
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [4:0]  s3;
    logic [4:0]  flt;
    mux_e        mux;
    logic        mclk;
    logic        wr_pend;
    logic [11:0] waddr;
    logic [31:0] rdata;
    logic [3:0]  ck;
    logic [7:0]  cc;
    logic [8:0]  ac;
    logic [5:0]  eoff;
    logic [47:0] esh;
    logic [95:0] ext;
  } top_s;

  top_s s_r;
  top_s s_nxt;

  logic [143:0] codec_words;
  logic [143:0] aux_words;
  logic [95:0]  codec_rx;
  logic         c_bit_rise;
  logic         c_frame_edge;
  logic         c_frame_lvl;
  logic         want_pll;
  logic         ext_lvl;
  logic         pll_lvl;

  // ****************************************************************
  // Words offered to each port, slot 0 in the low bits
  // ****************************************************************
  assign codec_words = {s_r.ext, adc2_sample, adc1_sample};
  assign aux_words   = s_r.ac[`PC_AUXSRC_BIT]
                       ? {s_r.ext, adc2_sample, adc1_sample}
                       : {s_r.ext, spdif_right, spdif_left};

  // Filtered clock levels and source wanted
  assign ext_lvl  = s_r.flt[0];
  assign pll_lvl  = s_r.flt[1];
  assign want_pll = (s_r.ck[1:0] == `SRC_MAN_PLL) ||
                    (s_r.ck[1] && (s_r.flt[2] || s_r.ck[`CK_FORCE_BIT]));

  // Next state: synchronisers, clock mux, bus, external converter capture
  always_comb
  begin
    logic        aphase;
    logic        lane_bit;
    logic        ext_fall;
    logic        pll_fall;
    s_nxt    = s_r;
    aphase   = hsel && htrans[1] && hready;
    lane_bit = 1'b0;
    ext_fall = 1'b0;
    pll_fall = 1'b0;
    // Three-stage synchronisers for clocks, lock and converter lines
    s_nxt.s1 = {ext_conv_in_2, ext_conv_in_1, pll_lock_in, pll_clk_in, ext_master_clk_in};
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < 5; i++)
    begin
      if (s_r.s2[i] == s_r.s3[i])
        s_nxt.flt[i] = s_r.s3[i];
    end
    // Filtered clock levels that fall at the coming edge
    ext_fall = ext_lvl & ~s_nxt.flt[0];
    pll_fall = pll_lvl & ~s_nxt.flt[1];
    // Master clock mux; a change lands with the old clock low and the new
    // one just falling, so the merged low phase is never cut short
    unique case (s_r.mux)
      MUX_EXT:
      begin
        s_nxt.mclk = ext_lvl;
        if (want_pll)
          s_nxt.mux = MUX_TO_PLL;
      end
      MUX_TO_PLL:
      begin
        s_nxt.mclk = ext_lvl;
        if (!want_pll)
          s_nxt.mux = MUX_EXT;
        else if (!ext_lvl && pll_fall)
        begin
          s_nxt.mux  = MUX_PLL;
          s_nxt.mclk = 1'b0;
        end
      end
      MUX_PLL:
      begin
        s_nxt.mclk = pll_lvl;
        if (!want_pll)
          s_nxt.mux = MUX_TO_EXT;
      end
      MUX_TO_EXT:
      begin
        s_nxt.mclk = pll_lvl;
        if (want_pll)
          s_nxt.mux = MUX_PLL;
        else if (!pll_lvl && ext_fall)
        begin
          s_nxt.mux  = MUX_EXT;
          s_nxt.mclk = 1'b0;
        end
      end
    endcase
    // Bus write in the data phase
    if (s_r.wr_pend)
    begin
      unique case (s_r.waddr)
        `OFS_CLK_CTRL:  s_nxt.ck = hwdata[3:0];
        `OFS_CODEC_CFG: s_nxt.cc = hwdata[7:0];
        `OFS_AUX_CFG:   s_nxt.ac = hwdata[8:0];
        default:        s_nxt.ck = s_r.ck;
      endcase
    end
    // Bus address phase; read data registered for the data phase
    s_nxt.wr_pend = aphase && hwrite;
    s_nxt.waddr   = haddr[11:0];
    if (aphase && !hwrite)
    begin
      unique case (haddr[11:0])
        `OFS_CLK_CTRL:  s_nxt.rdata = {28'h0, s_r.ck};
        `OFS_CODEC_CFG: s_nxt.rdata = {24'h0, s_r.cc};
        `OFS_AUX_CFG:   s_nxt.rdata = {23'h0, s_r.ac};
        `OFS_STATUS:    s_nxt.rdata = {29'h0, s_r.mux[1], s_r.flt[2], s_r.mux == MUX_PLL};
        default:        s_nxt.rdata = 32'h0;
      endcase
    end
    // External converter lines: left-justified 24 bits on codec port clocks
    if (c_frame_edge)
      s_nxt.eoff = 6'h00;
    else if (c_bit_rise)
    begin
      if (s_r.eoff <= `EXT_BIT_LAST)
      begin
        for (int l = 0; l < 2; l++)
        begin
          lane_bit = s_r.flt[3+l];
          s_nxt.esh[l*24 +: 24] = {s_r.esh[l*24 +: 23], lane_bit};
          if (s_r.eoff == `EXT_BIT_LAST)
          begin
            if (c_frame_lvl)
              s_nxt.ext[l*48 +: 24] = {s_r.esh[l*24 +: 23], lane_bit};
            else
              s_nxt.ext[l*48+24 +: 24] = {s_r.esh[l*24 +: 23], lane_bit};
          end
        end
      end
      if (s_r.eoff != 6'h3f)
        s_nxt.eoff = s_r.eoff + 6'h01;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r     <= '0;
      s_r.ck  <= `CK_CTRL_RST;
      s_r.cc  <= 8'(`PC_CFG_RST);
      s_r.ac  <= `PC_CFG_RST;
      s_r.mux <= MUX_EXT;
    end
    else
      s_r <= s_nxt;
  end

  // ****************************************************************
  // Serial ports, each with its own role, format and speed
  // ****************************************************************
  serial_port u_codec (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .mclk_rise  (s_nxt.mclk & ~s_r.mclk),
    .master     (s_r.cc[`PC_ROLE_BIT]),
    .fmt        (fmt_e'(s_r.cc[`PC_FMT_LSB +: 2])),
    .spd        (speed_e'(s_r.cc[`PC_SPD_LSB +: 2])),
    .bclk_half  (s_r.cc[`PC_DIV_LSB +: 3]),
    .tx_words   (codec_words),
    .bclk_in    (codec_port_bit_clk_in),
    .bclk_out   (codec_port_bit_clk_out),
    .bclk_oe    (codec_port_bit_clk_oe),
    .fclk_in    (codec_port_frame_clk_in),
    .fclk_out   (codec_port_frame_clk_out),
    .fclk_oe    (codec_port_frame_clk_oe),
    .din        ({codec_data_in_4, codec_data_in_3, codec_data_in_2, codec_data_in_1}),
    .dout       (codec_data_out),
    .rx_data    (codec_rx),
    .rx_slot    (dac_slot),
    .rx_valid   (dac_valid),
    .bit_rise   (c_bit_rise),
    .frame_edge (c_frame_edge),
    .frame_lvl  (c_frame_lvl)
  );

  serial_port u_aux (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .mclk_rise  (s_nxt.mclk & ~s_r.mclk),
    .master     (s_r.ac[`PC_ROLE_BIT]),
    .fmt        (fmt_e'(s_r.ac[`PC_FMT_LSB +: 2])),
    .spd        (speed_e'(s_r.ac[`PC_SPD_LSB +: 2])),
    .bclk_half  (s_r.ac[`PC_DIV_LSB +: 3]),
    .tx_words   (aux_words),
    .bclk_in    (aux_port_bit_clk_in),
    .bclk_out   (aux_port_bit_clk_out),
    .bclk_oe    (aux_port_bit_clk_oe),
    .fclk_in    (aux_port_frame_clk_in),
    .fclk_out   (aux_port_frame_clk_out),
    .fclk_oe    (aux_port_frame_clk_oe),
    .din        (4'h0),
    .dout       (aux_data_out),
    .rx_data    (),
    .rx_slot    (),
    .rx_valid   (),
    .bit_rise   (),
    .frame_edge (),
    .frame_lvl  ()
  );

  // Output wiring
  assign dac_data_1        = codec_rx[23:0];
  assign dac_data_2        = codec_rx[47:24];
  assign dac_data_3        = codec_rx[71:48];
  assign dac_data_4        = codec_rx[95:72];
  assign mclk_out          = s_r.mclk;
  assign pll_frame_ref_sel = s_r.ck[`CK_REF_BIT];
  assign force_lock_bit    = s_r.ck[`CK_FORCE_BIT];
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign hrdata            = s_r.rdata;

endmodule // audio_port_clocking

// >>> verif/audio_port_clocking_checker.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module apc_checker (
  // Clock, reset, bus answer
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  // Master clock, port pins, strobe
  input wire logic mclk_out,
  input wire logic codec_port_bit_clk_out,
  input wire logic codec_port_bit_clk_oe,
  input wire logic codec_port_frame_clk_oe,
  input wire logic aux_port_bit_clk_out,
  input wire logic aux_port_bit_clk_oe,
  input wire logic dac_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Bus answer, roles, clock shape, strobe
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  a_codec_quiet: assert property
    (!codec_port_bit_clk_oe |-> !codec_port_bit_clk_out)
    else $error("codec bit clock driven as slave");
  a_role_pair: assert property
    (codec_port_bit_clk_oe == codec_port_frame_clk_oe)
    else $error("codec clock enables differ");
  a_aux_quiet: assert property
    (!aux_port_bit_clk_oe |-> !aux_port_bit_clk_out)
    else $error("aux bit clock driven as slave");
  a_mclk_high: assert property ($rose(mclk_out) |=> mclk_out)
    else $error("runt high on master clock");
  a_mclk_low: assert property ($fell(mclk_out) |=> !mclk_out)
    else $error("runt low on master clock");
  a_dac_pulse: assert property (dac_valid |=> !dac_valid [*8])
    else $error("receive strobe too long");
  a_bclk_hold: assert property
    ($changed(codec_port_bit_clk_out) && codec_port_bit_clk_oe
     |=> ($stable(codec_port_bit_clk_out) || !codec_port_bit_clk_oe) [*3])
    else $error("bit clock phase too short");
endmodule // apc_checker

bind audio_port_clocking apc_checker chk_i (.ref_clk, .rst_n, .hreadyout, .hresp, .mclk_out,
  .codec_port_bit_clk_out, .codec_port_bit_clk_oe, .codec_port_frame_clk_oe,
  .aux_port_bit_clk_out, .aux_port_bit_clk_oe, .dac_valid);

// >>> verif/audio_partner.sv
`timescale 1ns/1ps
// ****
// Far-side audio processor
// ****
module audio_partner (
  // Frames run while high
  input  wire logic       run,
  // Slave clocks, data lines, converter lines
  output logic            bclk,
  output logic            fclk,
  output logic [5:0]      sd
);
  logic [23:0] w;
  // Frame high for left, bits change on bit clock fall
  initial
  begin
    bclk = 1'b0;
    fclk = 1'b0;
    sd   = 6'h00;
    forever
    begin
      // Polled off the sampling edge so pins never move on it
      while (!run) #10;
      for (int h = 0; h < 2; h++)
        for (int b = 0; b < 32; b++)
        begin
          bclk = 1'b0;
          fclk = (h == 0);
          for (int k = 0; k < 6; k++)
          begin
            w = {(h != 0) ? 8'h3c : 8'hc3, 4'(k), 12'h5a1};
            sd[k] = (b < 24) ? w[23 - b] : ~sd[k];
          end
          #100 bclk = 1'b1;
          #100;
        end
    end
  end
endmodule // audio_partner

// >>> verif/audio_port_clocking_tb.sv
`timescale 1ns/1ps
// ****
// Bench top
// ****
module audio_port_clocking_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        ext_clk = 1'b0;
  logic        pll_clk = 1'b0;
  logic        lock    = 1'b0;
  logic        run     = 1'b0;
  logic        hrdy;
  logic        mclk;
  logic        ref_sel;
  logic        frc;
  logic        bclk;
  logic        fclk;
  logic        cdo;
  logic        ado;
  logic        dv;
  logic [2:0]  slot;
  logic [3:0]  cp;
  logic [3:0]  ap;
  logic [5:0]  sd;
  logic [31:0] hrdata;
  logic [23:0] dac [4];
  logic [23:0] smp [4] = '{24'h8a1b2c, 24'h13579b, 24'hf0e1d2, 24'h0f1e2d};
  int          err_total = 0;
  int          compares  = 0;
  int          cyc       = 0;
  wire  [4:0]  watch = {ap[1], cp[1], ap[3], cp[3], mclk};
  wire  [1:0]  oes   = {ap[0], cp[0]};

  // Clocks: oscillator 10 MHz, PLL output slower
  always #12.5 ref_clk = ~ref_clk;
  always #50 ext_clk = ~ext_clk;
  always #75 pll_clk = ~pll_clk;

  audio_partner dsp (.run, .bclk, .fclk, .sd);

  audio_port_clocking uut (
    .ref_clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hrdy), .hreadyout(hrdy), .hresp(), .hrdata,
    .ext_master_clk_in(ext_clk), .pll_clk_in(pll_clk), .pll_lock_in(lock),
    .mclk_out(mclk), .pll_frame_ref_sel(ref_sel), .force_lock_bit(frc),
    .codec_port_bit_clk_in(bclk), .codec_port_bit_clk_out(cp[3]),
    .codec_port_bit_clk_oe(cp[0]), .codec_port_frame_clk_in(fclk),
    .codec_port_frame_clk_out(cp[1]), .codec_port_frame_clk_oe(cp[2]),
    .codec_data_in_1(sd[0]), .codec_data_in_2(sd[1]), .codec_data_in_3(sd[2]),
    .codec_data_in_4(sd[3]), .codec_data_out(cdo), .ext_conv_in_1(sd[4]),
    .ext_conv_in_2(sd[5]), .aux_port_bit_clk_in(bclk), .aux_port_bit_clk_out(ap[3]),
    .aux_port_bit_clk_oe(ap[0]), .aux_port_frame_clk_in(fclk),
    .aux_port_frame_clk_out(ap[1]), .aux_port_frame_clk_oe(ap[2]), .aux_data_out(ado),
    .adc1_sample(smp[0]), .adc2_sample(smp[1]), .spdif_left(smp[2]), .spdif_right(smp[3]),
    .dac_data_1(dac[0]), .dac_data_2(dac[1]), .dac_data_3(dac[2]), .dac_data_4(dac[3]),
    .dac_slot(slot), .dac_valid(dv));

  // Compare and verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One single bus transfer
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(nm, e, q);
  endtask

  // Rising edges of one watched line over n cycles
  task automatic rises(input int s, input int n, output int c);
    logic p;
    c = 0;
    p = watch[s];
    repeat (n)
    begin
      @(posedge ref_clk);
      c += (watch[s] && !p);
      p = watch[s];
    end
  endtask

  task automatic t_regs;
    rdc("clk_ctrl", 12'h000, 32'h2);
    rdc("codec_cfg", 12'h004, 32'h20);
    rdc("aux_cfg", 12'h008, 32'h20);
    rdc("unmapped", 12'h010, 32'h0);
    wr(12'h000, 32'he);
    rdc("clk_ctrl", 12'h000, 32'he);
    chk("ref_sel", 32'h1, {31'h0, ref_sel});
    chk("force", 32'h1, {31'h0, frc});
    $display("test regs done");
  endtask

  task automatic t_clock;
    logic [3:0] cv [5] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h6};
    logic       lk [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    int         ex [5] = '{24, 16, 16, 24, 16};
    int         st [5] = '{2, 1, 3, 0, 1};
    int         c;
    for (int i = 0; i < 5; i++)
    begin
      lock <= lk[i];
      wr(12'h000, {28'h0, cv[i]});
      repeat (40) @(posedge ref_clk);
      rises(0, 96, c);
      chk("mclk_rises", ex[i], c);
      rdc("status", 12'h00c, st[i]);
    end
    $display("test clock done");
  endtask

  task automatic t_rx;
    logic [23:0] e;
    wr(12'h004, 32'h28);
    run <= 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      do @(posedge ref_clk); while (!(dv === 1'b1 && slot === 3'(s)));
      for (int k = 0; k < 4; k++)
      begin
        e = {(s != 0) ? 8'h3c : 8'hc3, 4'(k), 12'h5a1};
        chk("dac_data", {8'h0, e}, {8'h0, dac[k]});
      end
    end
    $display("test rx done");
  endtask

  task automatic t_tx;
    logic [23:0] gc;
    logic [23:0] ga;
    logic [31:0] cfg [4] = '{32'h28, 32'h128, 32'h12c, 32'h12a};
    int          dl  [4] = '{0, 0, 8, 1};
    for (int m = 0; m < 4; m++)
    begin
      wr(12'h008, cfg[m]);
      @(posedge fclk);
      for (int s = 0; s < 2; s++)
      begin
        if (s != 0 || m == 3)
          @(fclk);
        repeat (dl[m]) @(posedge bclk);
        for (int b = 23; b >= 0; b--)
        begin
          @(posedge bclk);
          repeat (2) @(posedge ref_clk);
          gc[b] = cdo;
          ga[b] = ado;
        end
        if (m < 2)
          chk("codec_out", {8'h0, smp[s]}, {8'h0, gc});
        chk("aux_out", {8'h0, smp[(m != 0) ? s : s + 2]}, {8'h0, ga});
      end
    end
    $display("test tx done");
  endtask

  task automatic t_master;
    int c;
    wr(12'h000, 32'h0);
    for (int p = 0; p < 2; p++)
    begin
      wr(12'h004 + 12'(4 * p), 32'h29);
      repeat (8) @(posedge ref_clk);
      chk("bclk_oe", 32'h1, {31'h0, oes[p]});
      rises(p + 1, 64, c);
      chk("bclk_rises", 32'd4, c);
      chk("fclk_oe", 32'h1, {31'h0, (p != 0) ? ap[2] : cp[2]});
      rises(p + 3, 1024, c);
      chk("fclk_rises", 32'd1, c);
      wr(12'h004 + 12'(4 * p), 32'h28);
      repeat (8) @(posedge ref_clk);
      chk("bclk_oe", 32'h0, {31'h0, oes[p]});
    end
    $display("test master done");
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs;
    t_clock;
    t_rx;
    t_tx;
    t_master;
    report_and_stop;
  end

  // Hang limit
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop;
    end
  end
endmodule // audio_port_clocking_tb
